/* hra_pkg.sv */
// constants for the hid report and register access block
// Operation
// RULE_01: flag D0 on an invalid command, such as bad size, and skip it.
// RULE_02: abort and flag D1 when a byte sent to the target is refused.
// RULE_03: abort and flag D2 when bus arbitration is lost.
// RULE_04: flag D3 if bus not free in 256 ms or a byte exceeds 10 ms.
// RULE_05: report upper nibble echoes the sequence number of the command.
// RULE_06: report byte 1 holds the count of bytes written, 0 to 32.
// RULE_07: report byte 2 holds the count of bytes read, 0 to 32.
// RULE_08: report byte 3 is reserved with no meaning.
// RULE_09: a 32-byte read-data field always follows from byte 4, filled from start.
// RULE_10: host uses only as many data bytes as the read count says.
// RULE_11: five-byte report 0x3C writes 16-bit data to an address, low bytes first.
// RULE_12: three-byte report 0x4B latches a 16-bit read address, low byte first.
// RULE_13: read report 0x5A returns data at the latched address, low then high.
// RULE_14: host sets the read address before reading a register.
// RULE_15: every bus command gets exactly one status report back.
// RULE_16: latched read address holds until a new read-address report arrives.
package hra_pkg;
   // timing
   localparam int CLK_MHZ   = 250;
   localparam int FREE_MS   = 256;
   localparam int BYTE_MS   = 10;
   localparam int FREE_CYC  = FREE_MS * 1000 * CLK_MHZ;
   localparam int BYTE_CYC  = BYTE_MS * 1000 * CLK_MHZ;
   localparam int TMR_W     = 26;
   // report layout
   localparam logic [5:0] DATA_MAX  = 6'h20;
   localparam logic [5:0] HDR_LEN   = 6'h04;
   localparam logic [5:0] RPT_LAST  = 6'h23;
   localparam int FLG_REQ_ERR = 0;
   localparam int FLG_NAK     = 1;
   localparam int FLG_ARB     = 2;
   localparam int FLG_TMO     = 3;
   localparam logic [7:0] RSVD_BYTE = 8'h00;
   // feature report identifiers and lengths
   localparam logic [7:0] ID_REG_WR  = 8'h3C;
   localparam logic [7:0] ID_RD_ADDR = 8'h4B;
   localparam logic [7:0] ID_REG_RD  = 8'h5A;
   localparam logic [2:0] LEN_REG_WR = 3'h4;
   localparam logic [2:0] LEN_RD_ADR = 3'h2;
   // software registers
   localparam logic [7:0] A_CTRL   = 8'h00;
   localparam logic [7:0] A_STATUS = 8'h04;
   localparam logic [7:0] A_MASK   = 8'h08;
   localparam logic [7:0] A_LAST   = 8'h0C;
   localparam int EV_DONE = 0;
   localparam int EV_REQ  = 1;
   localparam int EV_NAK  = 2;
   localparam int EV_ARB  = 3;
   localparam int EV_TMO  = 4;
   localparam int EV_FWR  = 5;
   localparam int EV_FERR = 6;
   localparam int EV_W    = 7;
   localparam logic [EV_W-1:0] MASK_RST = 7'h00;
   localparam logic            EN_RST   = 1'b1;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_XFER = 2'b10,
      ST_RPT  = 2'b11
   } hra_state_type;
endpackage

/* hra_core.sv */
// hid status report builder and feature report register access
//
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module hra_core #(
   parameter int FREE_CYC = hra_pkg::FREE_CYC,
   parameter int BYTE_CYC = hra_pkg::BYTE_CYC
) (
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   // bus command from the out report decoder
   input  wire logic        i_cmd_valid,
   input  wire logic [3:0]  i_cmd_seq,
   input  wire logic [7:0]  i_cmd_wr_size,
   input  wire logic [7:0]  i_cmd_rd_size,
   output logic             o_cmd_ready,
   // two-wire bus engine
   output logic             o_xfer_start,
   output logic             o_xfer_abort,
   input  wire logic        i_bus_busy,
   input  wire logic        i_byte_active,
   input  wire logic        i_tx_byte,
   input  wire logic        i_rx_valid,
   input  wire logic [7:0]  i_rx_data,
   input  wire logic        i_nak,
   input  wire logic        i_arb_lost,
   input  wire logic        i_xfer_done,
   // status report stream to the in endpoint
   output logic             o_rpt_valid,
   output logic [7:0]       o_rpt_data,
   output logic             o_rpt_last,
   input  wire logic        i_rpt_ready,
   // feature set reports from the control endpoint
   input  wire logic        i_fset_valid,
   input  wire logic [7:0]  i_fset_data,
   input  wire logic        i_fset_last,
   // feature get request
   input  wire logic        i_fget_req,
   input  wire logic [7:0]  i_fget_id,
   output logic             o_fget_valid,
   output logic             o_fget_err,
   output logic [7:0]       o_fget_lsb,
   output logic [7:0]       o_fget_msb,
   // internal register map
   output logic             o_regw_en,
   output logic [15:0]      o_regw_addr,
   output logic [15:0]      o_regw_data,
   output logic [15:0]      o_regr_addr,
   input  wire logic [15:0] i_regr_data,
   // software register port
   input  wire logic [7:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic [31:0]      o_rdata,
   output logic             o_irq
);

   typedef struct packed {
      hra_pkg::hra_state_type  state;
      logic [3:0]              seq;
      logic [7:0]              flags;
      logic [5:0]              wr_cnt;
      logic [5:0]              rd_cnt;
      logic [31:0][7:0]        rbuf;
      logic [hra_pkg::TMR_W-1:0] tmr;
      logic                    cmd_ready;
      logic                    xfer_start;
      logic                    xfer_abort;
      logic                    rpt_valid;
      logic [7:0]              rpt_data;
      logic                    rpt_last;
      logic [5:0]              idx;
      logic [3:0][7:0]         fbuf;
      logic [2:0]              fcnt;
      logic [15:0]             rd_addr;
      logic                    regw_en;
      logic [15:0]             regw_addr;
      logic [15:0]             regw_data;
      logic                    fget_valid;
      logic                    fget_err;
      logic [7:0]              fget_lsb;
      logic [7:0]              fget_msb;
      logic                    ctrl_en;
      logic [hra_pkg::EV_W-1:0] status;
      logic [hra_pkg::EV_W-1:0] mask;
      logic [31:0]             rdata;
      logic                    irq;
   } hra_st_type;

   hra_st_type st_r;
   hra_st_type st_nxt;

   localparam logic [hra_pkg::TMR_W-1:0] FREE_LIM = hra_pkg::TMR_W'(FREE_CYC - 1);
   localparam logic [hra_pkg::TMR_W-1:0] BYTE_LIM = hra_pkg::TMR_W'(BYTE_CYC - 1);

   // byte of the status report at position i
   function automatic logic [7:0] rpt_byte(input hra_st_type s, input logic [5:0] i);
      logic [5:0] d;
      d = i - hra_pkg::HDR_LEN;
      case (i)
         6'h00:   rpt_byte = s.flags;
         6'h01:   rpt_byte = {2'h0, s.wr_cnt}; // RULE_06
         6'h02:   rpt_byte = {2'h0, s.rd_cnt}; // RULE_07
         6'h03:   rpt_byte = hra_pkg::RSVD_BYTE; // RULE_08
         default: rpt_byte = s.rbuf[d[4:0]]; // RULE_09
      endcase
   endfunction

   always_comb begin
      logic [hra_pkg::EV_W-1:0] ev;
      logic                     accept;
      logic                     bad;
      ev     = '0;
      st_nxt = st_r;
      st_nxt.xfer_start = 1'b0;
      st_nxt.xfer_abort = 1'b0;
      st_nxt.regw_en    = 1'b0;
      st_nxt.fget_valid = 1'b0;
      st_nxt.fget_err   = 1'b0;
      st_nxt.rdata      = 32'h0000_0000;
      accept = i_cmd_valid && st_r.cmd_ready;
      bad    = (i_cmd_wr_size > {2'h0, hra_pkg::DATA_MAX})
            || (i_cmd_rd_size > {2'h0, hra_pkg::DATA_MAX});

      case (st_r.state)
         hra_pkg::ST_IDLE: begin
            if (accept) begin
               st_nxt.seq    = i_cmd_seq;
               st_nxt.flags  = {i_cmd_seq, 4'h0}; // RULE_05
               st_nxt.wr_cnt = 6'h00;
               st_nxt.rd_cnt = 6'h00;
               st_nxt.rbuf   = '0;
               st_nxt.tmr    = '0;
               if (bad) begin
                  st_nxt.flags[hra_pkg::FLG_REQ_ERR] = 1'b1; // RULE_01
                  ev[hra_pkg::EV_REQ] = 1'b1;
                  st_nxt.state = hra_pkg::ST_RPT;
               end else begin
                  st_nxt.state = hra_pkg::ST_WAIT;
               end
            end
         end
         hra_pkg::ST_WAIT: begin
            if (!i_bus_busy) begin
               st_nxt.xfer_start = 1'b1;
               st_nxt.tmr        = '0;
               st_nxt.state      = hra_pkg::ST_XFER;
            end else if (st_r.tmr >= FREE_LIM) begin
               st_nxt.flags[hra_pkg::FLG_TMO] = 1'b1; // RULE_04
               ev[hra_pkg::EV_TMO] = 1'b1;
               st_nxt.state = hra_pkg::ST_RPT;
            end else begin
               st_nxt.tmr = st_r.tmr + 1'b1;
            end
         end
         hra_pkg::ST_XFER: begin
            if (i_tx_byte && st_r.wr_cnt < hra_pkg::DATA_MAX) begin
               st_nxt.wr_cnt = st_r.wr_cnt + 1'b1; // RULE_06
            end
            if (i_rx_valid && st_r.rd_cnt < hra_pkg::DATA_MAX) begin
               st_nxt.rbuf[st_r.rd_cnt[4:0]] = i_rx_data; // RULE_09
               st_nxt.rd_cnt = st_r.rd_cnt + 1'b1; // RULE_07
            end
            st_nxt.tmr = i_byte_active ? st_r.tmr + 1'b1 : '0;
            if (i_nak) begin
               st_nxt.flags[hra_pkg::FLG_NAK] = 1'b1; // RULE_02
               ev[hra_pkg::EV_NAK] = 1'b1;
               st_nxt.xfer_abort = 1'b1;
               st_nxt.state = hra_pkg::ST_RPT;
            end else if (i_arb_lost) begin
               st_nxt.flags[hra_pkg::FLG_ARB] = 1'b1; // RULE_03
               ev[hra_pkg::EV_ARB] = 1'b1;
               st_nxt.xfer_abort = 1'b1;
               st_nxt.state = hra_pkg::ST_RPT;
            end else if (i_byte_active && st_r.tmr >= BYTE_LIM) begin
               st_nxt.flags[hra_pkg::FLG_TMO] = 1'b1; // RULE_04
               ev[hra_pkg::EV_TMO] = 1'b1;
               st_nxt.xfer_abort = 1'b1;
               st_nxt.state = hra_pkg::ST_RPT;
            end else if (i_xfer_done) begin
               st_nxt.state = hra_pkg::ST_RPT;
            end
         end
         hra_pkg::ST_RPT: begin
            // one 36-byte report per command
            if (!st_r.rpt_valid) begin
               st_nxt.rpt_valid = 1'b1;
               st_nxt.idx       = 6'h00;
               st_nxt.rpt_data  = rpt_byte(st_r, 6'h00);
               st_nxt.rpt_last  = 1'b0;
            end else if (i_rpt_ready) begin
               if (st_r.rpt_last) begin
                  st_nxt.rpt_valid = 1'b0; // RULE_15
                  st_nxt.rpt_last  = 1'b0;
                  ev[hra_pkg::EV_DONE] = 1'b1;
                  st_nxt.state = hra_pkg::ST_IDLE;
               end else begin
                  st_nxt.idx      = st_r.idx + 1'b1;
                  st_nxt.rpt_data = rpt_byte(st_r, st_nxt.idx);
                  st_nxt.rpt_last = (st_nxt.idx == hra_pkg::RPT_LAST); // RULE_09
               end
            end
         end
         default: st_nxt.state = hra_pkg::ST_IDLE;
      endcase

      // feature set reports
      if (i_fset_valid) begin
         if (i_fset_last) begin
            st_nxt.fcnt = 3'h0;
            if (st_r.fbuf[0] == hra_pkg::ID_REG_WR && st_r.fcnt == hra_pkg::LEN_REG_WR) begin
               st_nxt.regw_en   = 1'b1; // RULE_11
               st_nxt.regw_addr = {st_r.fbuf[2], st_r.fbuf[1]};
               st_nxt.regw_data = {i_fset_data, st_r.fbuf[3]};
               ev[hra_pkg::EV_FWR] = 1'b1;
            end else if (st_r.fbuf[0] == hra_pkg::ID_RD_ADDR
                         && st_r.fcnt == hra_pkg::LEN_RD_ADR) begin
               st_nxt.rd_addr = {i_fset_data, st_r.fbuf[1]}; // RULE_12 RULE_16
            end else begin
               ev[hra_pkg::EV_FERR] = 1'b1;
            end
         end else if (st_r.fcnt < hra_pkg::LEN_REG_WR) begin
            st_nxt.fbuf[st_r.fcnt[1:0]] = i_fset_data;
            st_nxt.fcnt = st_r.fcnt + 1'b1;
         end else begin
            st_nxt.fcnt = 3'h5;
         end
      end

      // feature get reports
      if (i_fget_req) begin
         if (i_fget_id == hra_pkg::ID_REG_RD) begin
            st_nxt.fget_valid = 1'b1; // RULE_13
            st_nxt.fget_lsb   = i_regr_data[7:0];
            st_nxt.fget_msb   = i_regr_data[15:8];
         end else begin
            st_nxt.fget_err = 1'b1;
            ev[hra_pkg::EV_FERR] = 1'b1;
         end
      end

      // software registers, status set wins over clear
      st_nxt.status = st_r.status;
      if (i_wr) begin
         case (i_addr)
            hra_pkg::A_CTRL:   st_nxt.ctrl_en = i_wdata[0];
            hra_pkg::A_STATUS: st_nxt.status = st_r.status & ~i_wdata[hra_pkg::EV_W-1:0];
            hra_pkg::A_MASK:   st_nxt.mask = i_wdata[hra_pkg::EV_W-1:0];
            default: ;
         endcase
      end
      st_nxt.status = st_nxt.status | ev;
      if (i_rd) begin
         case (i_addr)
            hra_pkg::A_CTRL:   st_nxt.rdata = {31'h0, st_r.ctrl_en};
            hra_pkg::A_STATUS: st_nxt.rdata = {25'h0, st_r.status};
            hra_pkg::A_MASK:   st_nxt.rdata = {25'h0, st_r.mask};
            hra_pkg::A_LAST:   st_nxt.rdata = {8'h00, 2'h0, st_r.rd_cnt,
                                               2'h0, st_r.wr_cnt, st_r.flags};
            default:           st_nxt.rdata = 32'h0000_0000;
         endcase
      end
      st_nxt.irq       = |(st_nxt.status & st_nxt.mask);
      st_nxt.cmd_ready = (st_nxt.state == hra_pkg::ST_IDLE) && st_nxt.ctrl_en;
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         st_r         <= '0;
         st_r.state   <= hra_pkg::ST_IDLE;
         st_r.ctrl_en <= hra_pkg::EN_RST;
         st_r.mask    <= hra_pkg::MASK_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_cmd_ready  = st_r.cmd_ready;
   assign o_xfer_start = st_r.xfer_start;
   assign o_xfer_abort = st_r.xfer_abort;
   assign o_rpt_valid  = st_r.rpt_valid;
   assign o_rpt_data   = st_r.rpt_data;
   assign o_rpt_last   = st_r.rpt_last;
   assign o_fget_valid = st_r.fget_valid;
   assign o_fget_err   = st_r.fget_err;
   assign o_fget_lsb   = st_r.fget_lsb;
   assign o_fget_msb   = st_r.fget_msb;
   assign o_regw_en    = st_r.regw_en;
   assign o_regw_addr  = st_r.regw_addr;
   assign o_regw_data  = st_r.regw_data;
   assign o_regr_addr  = st_r.rd_addr;
   assign o_rdata      = st_r.rdata;
   assign o_irq        = st_r.irq;

   // checks
   sequence s_accept_bad;
      i_cmd_valid && o_cmd_ready
      && (i_cmd_wr_size > 8'h20 || i_cmd_rd_size > 8'h20);
   endsequence
   sequence s_last_beat;
      o_rpt_valid && o_rpt_last && i_rpt_ready;
   endsequence

   a_bad_size_err: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_01
      s_accept_bad |=> st_r.flags[0] && st_r.state == hra_pkg::ST_RPT && !o_xfer_start)
      else $error("bad size not flagged");
   a_nak_abort: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_02
      st_r.state == hra_pkg::ST_XFER && i_nak |=> o_xfer_abort && st_r.flags[1])
      else $error("nak did not abort");
   a_arb_abort: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_03
      st_r.state == hra_pkg::ST_XFER && i_arb_lost && !i_nak
      |=> o_xfer_abort && st_r.flags[2])
      else $error("arbitration loss not flagged");
   a_free_timeout: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_04
      st_r.state == hra_pkg::ST_WAIT && i_bus_busy && st_r.tmr == FREE_LIM
      |=> st_r.flags[3] && st_r.state == hra_pkg::ST_RPT)
      else $error("bus free timeout missed");
   a_seq_echo: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_05
      o_rpt_valid && st_r.idx == 6'h00 |-> o_rpt_data[7:4] == st_r.seq)
      else $error("sequence number not echoed");
   a_count_bytes: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_06
      o_rpt_valid && st_r.idx == 6'h01 |-> o_rpt_data <= 8'h20
      && o_rpt_data == {2'h0, st_r.wr_cnt})
      else $error("write count wrong");
   a_rsvd_byte: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_08
      o_rpt_valid && st_r.idx == 6'h03 |-> o_rpt_data == 8'h00)
      else $error("reserved byte not zero");
   a_report_len: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_09
      o_rpt_valid && o_rpt_last |-> st_r.idx == 6'h23)
      else $error("report length not 36");
   a_one_report: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_15
      s_last_beat |=> !o_rpt_valid && st_r.state == hra_pkg::ST_IDLE)
      else $error("report did not end once");
   a_reg_write: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_11
      i_fset_valid && i_fset_last && st_r.fbuf[0] == 8'h3C && st_r.fcnt == 3'h4
      |=> o_regw_en && o_regw_data[15:8] == $past(i_fset_data))
      else $error("register write missed");
   a_addr_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_16
      !(i_fset_valid && i_fset_last) |=> $stable(o_regr_addr))
      else $error("read address changed");
   a_reg_read: assert property (@(posedge i_clk) disable iff (i_sys_rst) // RULE_13
      i_fget_req && i_fget_id == 8'h5A
      |=> o_fget_valid && {o_fget_msb, o_fget_lsb} == $past(i_regr_data))
      else $error("register read data wrong");

endmodule
`default_nettype wire

/* hra_host_model.sv */
// host model that takes status reports from the in endpoint
`timescale 1ns/1ps
`default_nettype none
module hra_host_model (
   // clock
   input  wire logic       i_clk,
   // report stream
   input  wire logic       i_rpt_valid,
   input  wire logic [7:0] i_rpt_data,
   input  wire logic       i_rpt_last,
   output logic            o_rpt_ready,
   // pacing and capture
   input  wire logic       i_slow,
   output logic [35:0][7:0] o_buf,
   output int              o_len,
   output int              o_count
);
   logic tog = 1'b0;
   int   idx = 0;
   int   len = 0;
   int   cnt = 0;
   // slow host stalls every other cycle
   assign o_rpt_ready = i_slow ? tog : 1'b1;
   assign o_len       = len;
   assign o_count     = cnt;
   always @(posedge i_clk) begin
      tog <= ~tog;
      if (i_rpt_valid && o_rpt_ready) begin
         if (idx < 36) begin
            o_buf[idx] <= i_rpt_data;
         end
         idx <= idx + 1;
         if (i_rpt_last) begin
            len <= idx + 1;
            cnt <= cnt + 1;
            idx <= 0;
         end
      end
   end
endmodule
`default_nettype wire

/* hid_report_register_access_tb.sv */
// self-checking bench for the hid report and register access block
`timescale 1ns/1ps
`default_nettype none
module hid_report_register_access_tb;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        cmd_valid = 1'b0, busy = 1'b0, act = 1'b0, slow = 1'b0;
   logic [3:0]  cmd_seq = 4'h0;
   logic [7:0]  cmd_wr = 8'h00, cmd_rd = 8'h00, rx_data = 8'h00;
   logic [4:0]  ev = 5'h00;
   logic        fs_valid = 1'b0, fs_last = 1'b0, fg_req = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [7:0]  fs_data = 8'h00, fg_id = 8'h00, addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic        cmd_ready, xs, xa, rv, rl, rr, fgv, fge, rwe, irq;
   logic [7:0]  rdat, fgl, fgm;
   logic [15:0] rwa, rwd, rra, rrd;
   logic [31:0] rdata;
   logic [35:0][7:0] hbuf;
   int          hlen, hcnt;
   int          failures = 0;
   int          tests_run = 0;
   logic        start_seen = 1'b0, abort_seen = 1'b0;
   logic [3:0]  fl [0:5] = '{4'h0, 4'h2, 4'h4, 4'h8, 4'h8, 4'h1};
   logic [31:0] v;
   // register map model: data is the inverted address
   assign rrd = ~rra;
   initial begin
      forever #2 clk = ~clk;
   end
   hra_core #(.FREE_CYC(40), .BYTE_CYC(20)) dut (
      .i_clk(clk), .i_sys_rst(rst), .i_cmd_valid(cmd_valid), .i_cmd_seq(cmd_seq),
      .i_cmd_wr_size(cmd_wr), .i_cmd_rd_size(cmd_rd), .o_cmd_ready(cmd_ready),
      .o_xfer_start(xs), .o_xfer_abort(xa), .i_bus_busy(busy), .i_byte_active(act),
      .i_tx_byte(ev[0]), .i_rx_valid(ev[1]), .i_rx_data(rx_data), .i_nak(ev[2]),
      .i_arb_lost(ev[3]), .i_xfer_done(ev[4]), .o_rpt_valid(rv), .o_rpt_data(rdat),
      .o_rpt_last(rl), .i_rpt_ready(rr), .i_fset_valid(fs_valid), .i_fset_data(fs_data),
      .i_fset_last(fs_last), .i_fget_req(fg_req), .i_fget_id(fg_id), .o_fget_valid(fgv),
      .o_fget_err(fge), .o_fget_lsb(fgl), .o_fget_msb(fgm), .o_regw_en(rwe),
      .o_regw_addr(rwa), .o_regw_data(rwd), .o_regr_addr(rra), .i_regr_data(rrd),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq));
   hra_host_model host (.i_clk(clk), .i_rpt_valid(rv), .i_rpt_data(rdat), .i_rpt_last(rl),
      .o_rpt_ready(rr), .i_slow(slow), .o_buf(hbuf), .o_len(hlen), .o_count(hcnt));
   always @(posedge clk) begin
      if (xs === 1'b1) start_seen = 1'b1;
      if (xa === 1'b1) abort_seen = 1'b1;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
         failures++;
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic hang;
      failures++;
      report_and_stop();
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic strobe(input int k, input logic [7:0] d);
      @(posedge clk);
      ev <= 5'h01 << k;
      rx_data <= d;
      @(posedge clk);
      ev <= 5'h00;
   endtask
   task automatic fset(input int n, input logic [39:0] b);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         fs_valid <= 1'b1;
         fs_data <= b[8*i +: 8];
         fs_last <= (i == n - 1);
      end
      @(posedge clk);
      fs_valid <= 1'b0;
      fs_last <= 1'b0;
      #1;
   endtask
   task automatic fget(input logic [7:0] id);
      @(posedge clk);
      fg_req <= 1'b1;
      fg_id <= id;
      @(posedge clk);
      fg_req <= 1'b0;
      #1;
   endtask
   // mode: 0 done, 1 refused byte, 2 lost bus, 3 byte stuck, 4 bus busy, 5 bad size
   task automatic do_cmd(input logic [3:0] s, input int w, input int r, input int m,
                         input logic sl);
      int n, k, ew, er;
      n = hcnt;
      ew = (m == 0) ? w : ((m == 1) ? 1 : 0);
      er = (m == 0) ? r : 0;
      for (k = 0; k < 100 && cmd_ready !== 1'b1; k++) @(negedge clk);
      if (k == 100) hang();
      start_seen = 1'b0;
      abort_seen = 1'b0;
      @(posedge clk);
      slow <= sl;
      busy <= (m == 4);
      cmd_seq <= s;
      cmd_wr <= w[7:0];
      cmd_rd <= r[7:0];
      cmd_valid <= 1'b1;
      @(posedge clk);
      cmd_valid <= 1'b0;
      if (m < 4) begin
         for (k = 0; k < 50 && start_seen !== 1'b1; k++) @(negedge clk);
         if (k == 50) hang();
      end
      if (m == 0) begin
         for (int i = 0; i < w; i++) strobe(0, 8'h00);
         for (int i = 0; i < r; i++) strobe(1, 8'h10 + i[7:0]);
         strobe(4, 8'h00);
      end
      if (m == 1) strobe(0, 8'h00);
      if (m == 1 || m == 2) strobe(m + 1, 8'h00);
      if (m == 3) @(posedge clk) act <= 1'b1;
      for (k = 0; k < 600 && hcnt == n; k++) @(negedge clk);
      if (k == 600) hang();
      @(posedge clk);
      busy <= 1'b0;
      act <= 1'b0;
      chk(hbuf[0], {s, fl[m]});
      chk(hbuf[1], ew);
      chk(hbuf[2], er);
      chk(hbuf[3], 8'h00);
      chk(hlen, 36);
      for (int i = 0; i < er; i++) chk(hbuf[4 + i], 8'h10 + i);
      chk(hcnt, n + 1);
      chk(start_seen, m < 4);
      chk(abort_seen, m >= 1 && m <= 3);
   endtask
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      reg_rd(hra_pkg::A_CTRL, v);
      chk(v, 32'h0000_0001);
      reg_rd(hra_pkg::A_MASK, v);
      chk(v, 32'h0000_0000);
      reg_rd(8'h10, v);
      chk(v, 32'h0000_0000);
      do_cmd(4'h5, 2, 3, 0, 1'b0);
      reg_rd(hra_pkg::A_LAST, v);
      chk(v, {10'h000, 6'h03, 2'h0, 6'h02, 8'h50});
      do_cmd(4'hA, 32, 32, 0, 1'b1);
      do_cmd(4'h3, 33, 0, 5, 1'b0);
      do_cmd(4'hC, 0, 33, 5, 1'b1);
      do_cmd(4'h1, 4, 0, 1, 1'b0);
      do_cmd(4'h2, 0, 2, 2, 1'b0);
      do_cmd(4'h7, 1, 0, 3, 1'b1);
      do_cmd(4'hF, 0, 0, 4, 1'b0);
      reg_rd(hra_pkg::A_STATUS, v);
      chk(v, 32'h0000_001F);
      chk(irq, 1'b0);
      reg_wr(hra_pkg::A_STATUS, 32'h0000_007F);
      reg_wr(hra_pkg::A_MASK, 32'h0000_0040);
      fset(5, 40'hBE_EF12_343C);
      chk({rwe, rwa, rwd}, {1'b1, 16'h1234, 16'hBEEF});
      fset(4, 40'h00_EF12_343C);
      chk(rwe, 1'b0);
      reg_rd(hra_pkg::A_STATUS, v);
      chk(v, 32'h0000_0060);
      chk(irq, 1'b1);
      reg_wr(hra_pkg::A_STATUS, 32'h0000_0040);
      reg_rd(hra_pkg::A_STATUS, v);
      chk(v, 32'h0000_0020);
      chk(irq, 1'b0);
      fset(3, 40'h00_000C_1D4B);
      chk(rra, 16'h0C1D);
      fget(8'h5A);
      chk({fgv, fgm, fgl}, {1'b1, 16'hF3E2});
      fset(5, 40'h00_0100_023C);
      fset(2, 40'h00_0000_774B);
      fget(8'h5A);
      chk({fgv, fgm, fgl}, {1'b1, 16'hF3E2});
      fget(8'h11);
      chk({fge, fgv}, 2'h2);
      // commands disabled: ready must drop and stay low
      reg_wr(hra_pkg::A_CTRL, 32'h0000_0000);
      @(negedge clk);
      chk(cmd_ready, 1'b0);
      reg_rd(hra_pkg::A_CTRL, v);
      chk(v, 32'h0000_0000);
      chk(cmd_ready, 1'b0);
      reg_wr(hra_pkg::A_CTRL, 32'h0000_0001);
      @(negedge clk);
      chk(cmd_ready, 1'b1);
      report_and_stop();
   end
endmodule
`default_nettype wire
